// ---- cpc_map.vh ----
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

// Register byte offsets on the APB
`define CPC_OFS_U1_LOW   8'h00
`define CPC_OFS_U1_HIGH  8'h04
`define CPC_OFS_U1_CTL   8'h08
`define CPC_OFS_U2_LOW   8'h0C
`define CPC_OFS_U2_HIGH  8'h10
`define CPC_OFS_U2_CTL   8'h14
`define CPC_OFS_FLAGS    8'h18
`define CPC_OFS_IRQ_EN   8'h1C
`define CPC_OFS_TB_SEL   8'h20
`define CPC_OFS_STATUS   8'h24

// Reset values
`define CPC_RST_BYTE     8'h00
`define CPC_RST_CTL      6'h00
`define CPC_RST_BITS     2'h0

// Control register fields
`define CPC_CTL_MODE     3:0
`define CPC_CTL_DUTY_LO  5:4
`define CPC_CTL_WIDTH    6

// Mode-select codes
`define CPC_MODE_OFF     4'h0
`define CPC_MODE_TOGGLE  4'h2
`define CPC_MODE_SET     4'h8
`define CPC_MODE_CLEAR   4'h9
`define CPC_MODE_SWI     4'hA
`define CPC_MODE_TRIG    4'hB
`define CPC_GRP_COMPARE  2'h2
`define CPC_GRP_PWM      2'h3

`endif

// ---- cpc_top.v ----
// Behaviour
// - Compare 16-bit match value against selected first or third timer count.
// - On match drive pin high, low, toggle or leave, per mode bits.
// - Match flag sets on the same edge as the pin action.
// - Control write of zero or of set mode forces compare/PWM output latch low.
// - Software-interrupt mode leaves pin alone; interrupt reaches core if enabled.
// - Special trigger match pulses a reset of the selected time base.
// - Second unit trigger also starts conversion when converter enabled.
// - Trigger-caused timer reset never sets timer overflow flags.
// - PWM mode produces up to 10-bit resolution waveform on pin.
// - At period match on increment: timer clears, pin sets unless 0%, duty loads.
// - Postscaler plays no part in PWM period.
// - Duty is match-low byte as MSBs plus control bits 5:4 as LSBs.
// - Duty writable anytime; double buffered, updated only at period end.
// - Match-high register read-only to software in PWM mode.
// - Pin clears when active duty equals period count with two fine bits.
// - Duty beyond period never clears pin, output stays high.
// - Mode codes: 0000 off, 0010 toggle, 1000/1001 set/clear, 1010, 1011, 11xx.
// - Time base choice per unit comes from third-timer select bits.
`timescale 1ns/1ns
`include "cpc_map.vh"

module cpc_top
(
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] first_timer_count,
  input  wire [15:0] third_timer_count,
  input  wire [7:0]  period_timer_count,
  input  wire [7:0]  period_limit,
  input  wire        period_inc,
  input  wire [1:0]  period_fine,
  input  wire        adc_enable,
  output wire        unit1_output_pin,
  output wire        unit2_output_pin,
  output reg         unit1_irq,
  output reg         unit2_irq,
  output reg         first_timer_reset,
  output reg         third_timer_reset,
  output reg         adc_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg  [7:0]  match_low [0:1];
  reg  [7:0]  match_high [0:1];
  reg  [5:0]  control [0:1];
  reg  [1:0]  match_flag;
  reg  [1:0]  irq_enable;
  reg  [1:0]  third_timer_control;
  wire [1:0]  hit_v;
  wire [1:0]  trig_v;
  wire [1:0]  pwm_load;
  wire [1:0]  pwm_on;
  wire [1:0]  pin_v;
  wire [1:0]  next_match_flag;
  reg  [31:0] next_prdata;
  reg         next_slverr;
  integer     k;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire        acc    = psel & penable & pready;
  wire        wr     = acc & pwrite;
  wire [1:0]  lo_wr  = {wr & (paddr == `CPC_OFS_U2_LOW), wr & (paddr == `CPC_OFS_U1_LOW)};
  wire [1:0]  hi_wr  = {wr & (paddr == `CPC_OFS_U2_HIGH), wr & (paddr == `CPC_OFS_U1_HIGH)};
  wire [1:0]  ctl_wr = {wr & (paddr == `CPC_OFS_U2_CTL), wr & (paddr == `CPC_OFS_U1_CTL)};
  wire        fl_wr  = wr & (paddr == `CPC_OFS_FLAGS);
  wire [1:0]  fl_clr = fl_wr ? pwdata[1:0] : `CPC_RST_BITS;

  // Zero-wait slave: pready rises in the cycle after setup
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      // Error stands only with pready, never past the access cycle
      pslverr <= psel & ~penable & next_slverr;
      if (psel & ~penable)
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `CPC_OFS_U1_LOW:  next_prdata[7:0] = match_low[0];
      `CPC_OFS_U1_HIGH: next_prdata[7:0] = match_high[0];
      `CPC_OFS_U1_CTL:  next_prdata[5:0] = control[0];
      `CPC_OFS_U2_LOW:  next_prdata[7:0] = match_low[1];
      `CPC_OFS_U2_HIGH: next_prdata[7:0] = match_high[1];
      `CPC_OFS_U2_CTL:  next_prdata[5:0] = control[1];
      `CPC_OFS_FLAGS:   next_prdata[1:0] = match_flag;
      `CPC_OFS_IRQ_EN:  next_prdata[1:0] = irq_enable;
      `CPC_OFS_TB_SEL:  next_prdata[1:0] = third_timer_control;
      `CPC_OFS_STATUS:  next_prdata[3:0] = {pwm_on, pin_v};
      default:          next_slverr = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  assign next_match_flag = (match_flag & ~fl_clr) | hit_v;

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        match_low[k]  <= `CPC_RST_BYTE;
        match_high[k] <= `CPC_RST_BYTE;
        control[k]    <= `CPC_RST_CTL;
      end
      match_flag          <= `CPC_RST_BITS;
      irq_enable          <= `CPC_RST_BITS;
      third_timer_control <= `CPC_RST_BITS;
    end
    else
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        if (lo_wr[k])
          match_low[k] <= pwdata[7:0];
        if (pwm_load[k])
          match_high[k] <= match_low[k];
        else if (hi_wr[k] & ~pwm_on[k])
          match_high[k] <= pwdata[7:0];
        if (ctl_wr[k])
          control[k] <= pwdata[5:0];
      end
      match_flag <= next_match_flag;
      if (wr & (paddr == `CPC_OFS_IRQ_EN))
        irq_enable <= pwdata[1:0];
      if (wr & (paddr == `CPC_OFS_TB_SEL))
        third_timer_control <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit compare and PWM engine

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : unit
      reg        eq_q;
      reg        pin;
      reg  [1:0] duty_latch;
      wire [3:0] mode      = control[i][`CPC_CTL_MODE];
      wire [3:0] new_mode  = pwdata[3:0];
      wire [15:0] tbase    = third_timer_control[i] ? third_timer_count : first_timer_count;
      wire        eq       = ({match_high[i], match_low[i]} == tbase);
      wire        cmp      = (mode == `CPC_MODE_TOGGLE) | (mode[3:2] == `CPC_GRP_COMPARE);
      wire        pwm      = (mode[3:2] == `CPC_GRP_PWM);
      // Equality seen once; a timer parked on the value acts once
      wire        hit      = cmp & eq & ~eq_q;
      wire [9:0]  duty_new = {match_low[i], control[i][`CPC_CTL_DUTY_LO]};
      wire        load     = pwm & period_inc & (period_timer_count == period_limit);
      // Registered pin: compare one fine step ahead so the edge lands on the match
      wire [9:0]  next_idx = {period_timer_count, period_fine} + 10'h001;
      wire        dclr     = ({match_high[i], duty_latch} == next_idx);

      assign hit_v[i]    = hit;
      assign trig_v[i]   = hit & (mode == `CPC_MODE_TRIG);
      assign pwm_load[i] = load;
      assign pwm_on[i]   = pwm;
      assign pin_v[i]    = pin;

      always @(posedge sys_clk)
      begin
        if (reset)
        begin
          eq_q       <= 1'b0;
          pin        <= 1'b0;
          duty_latch <= `CPC_RST_BITS;
        end
        else
        begin
          eq_q <= eq;
          if (load)
            duty_latch <= control[i][`CPC_CTL_DUTY_LO];
          if (ctl_wr[i])
          begin
            if (new_mode == `CPC_MODE_CLEAR)
              pin <= 1'b1;
            else if ((new_mode == `CPC_MODE_OFF) | (new_mode == `CPC_MODE_SET))
              pin <= 1'b0;
          end
          else if (mode == `CPC_MODE_OFF)
            pin <= 1'b0;
          else if (pwm)
          begin
            if (load)
              pin <= (duty_new != 10'h000);
            else if (dclr)
              pin <= 1'b0;
          end
          else if (hit)
          begin
            case (mode)
              `CPC_MODE_TOGGLE: pin <= ~pin;
              `CPC_MODE_SET:    pin <= 1'b1;
              `CPC_MODE_CLEAR:  pin <= 1'b0;
              default:          pin <= pin;
            endcase
          end
        end
      end
    end
  endgenerate

  assign unit1_output_pin = unit[0].pin;
  assign unit2_output_pin = unit[1].pin;

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      unit1_irq         <= 1'b0;
      unit2_irq         <= 1'b0;
      first_timer_reset <= 1'b0;
      third_timer_reset <= 1'b0;
      adc_start         <= 1'b0;
    end
    else
    begin
      unit1_irq <= next_match_flag[0] & irq_enable[0];
      unit2_irq <= next_match_flag[1] & irq_enable[1];
      first_timer_reset <= |(trig_v & ~third_timer_control);
      third_timer_reset <= |(trig_v & third_timer_control);
      adc_start <= trig_v[1] & adc_enable;
    end
  end

endmodule // cpc_top

// ---- cpc_sva.sv ----
`timescale 1ns/1ns
module cpc_chk
(
  input logic        sys_clk,
  input logic        reset,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic        adc_enable,
  input logic        unit1_output_pin,
  input logic        unit1_irq,
  input logic        first_timer_reset,
  input logic        third_timer_reset,
  input logic        adc_start
);
  wire wr_ctl0 = psel & penable & pready & pwrite & (paddr == 8'h08) & (pwdata[7:0] == 8'h00);
  wire wr_flag = psel & penable & pwrite & ((paddr == 8'h18) | (paddr == 8'h1C));
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_drop_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  ctl_zero_a: assert property (wr_ctl0 |=> !unit1_output_pin)
    else $error("pin not low after control clear");
  trig_pin_a: assert property (first_timer_reset |-> $stable(unit1_output_pin))
    else $error("trigger moved pin");
  trig_pulse_a: assert property (third_timer_reset |=> !third_timer_reset)
    else $error("timer clear longer than one cycle");
  adc_gate_a: assert property (adc_start |-> $past(adc_enable))
    else $error("conversion while converter off");
  adc_trig_a: assert property (adc_start |-> first_timer_reset || third_timer_reset)
    else $error("conversion without timer clear");
  irq_hold_a: assert property ($fell(unit1_irq) |-> $past(wr_flag))
    else $error("irq dropped without software");
endmodule // cpc_chk

bind cpc_top cpc_chk i_cpc_chk (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .adc_enable(adc_enable), .unit1_output_pin(unit1_output_pin), .unit1_irq(unit1_irq),
  .first_timer_reset(first_timer_reset), .third_timer_reset(third_timer_reset), .adc_start(adc_start));

// ---- cpc_load.sv ----
`timescale 1ns/1ns
module cpc_load
(
  input  logic        sys_clk,
  input  logic        pin,
  output logic [15:0] run_len,
  output logic [15:0] high_w
);
  initial run_len = 16'h0000;
  initial high_w = 16'h0000;
  always @(negedge sys_clk)
  begin
    if (pin === 1'b1)
      run_len <= run_len + 16'h0001;
    else
    begin
      if (run_len != 16'h0000)
        high_w <= run_len;
      run_len <= 16'h0000;
    end
  end
endmodule // cpc_load

// ---- cpc_top_tb.sv ----
`timescale 1ns/1ns
module cpc_top_tb;
  logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, period_timer_count = 0, period_limit = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] first_timer_count = 0, third_timer_count = 0, run_len, high_w;
  logic [1:0]  period_fine = 0;
  logic        period_inc = 0, adc_enable = 0, run = 0, pready, pslverr, err;
  logic        unit1_output_pin, unit1_irq, first_timer_reset, third_timer_reset, adc_start;
  int          miscompares = 0, total_checks = 0, cycles = 0, n_t1 = 0, n_t3 = 0, n_adc = 0;
  always #5 sys_clk = ~sys_clk;
  cpc_top i_cpc_top (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_timer_count(first_timer_count), .third_timer_count(third_timer_count),
    .period_timer_count(period_timer_count), .period_limit(period_limit), .period_inc(period_inc),
    .period_fine(period_fine), .adc_enable(adc_enable), .unit1_output_pin(unit1_output_pin),
    .unit2_output_pin(), .unit1_irq(unit1_irq), .unit2_irq(), .first_timer_reset(first_timer_reset),
    .third_timer_reset(third_timer_reset), .adc_start(adc_start));
  cpc_load i_cpc_load (.sys_clk(sys_clk), .pin(unit1_output_pin), .run_len(run_len), .high_w(high_w));
  ////////////////////////////////////////
  // Period timer stands outside the block
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    period_fine <= run ? period_fine + 2'd1 : 2'd0;
    period_inc <= run && period_fine == 2'd2;
    if (period_inc)
      period_timer_count <= (period_timer_count == period_limit) ? 8'h00 : period_timer_count + 8'h01;
    if (cycles == 3000)
    begin
      miscompares++;
      close_out();
    end
  end
  always @(negedge sys_clk)
  begin
    n_t1 += first_timer_reset;
    n_t3 += third_timer_reset;
    n_adc += adc_start;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic t_regs();
    apb(0, 8'h08, 0);
    chk(rd, 0);
    apb(0, 8'h28, 0);
    chk(err, 1);
    $display("t_regs done");
  endtask
  task automatic t_cmp();
    logic [4:0] pre = 5'b00100, post = 5'b00011;
    logic [3:0] md;
    apb(1, 8'h00, 32'h34);
    apb(1, 8'h04, 32'h12);
    apb(1, 8'h1C, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      md = (i == 0) ? 4'h2 : 4'(7 + i);
      apb(1, 8'h08, 0);
      chk(unit1_output_pin, 0);
      apb(1, 8'h08, {28'h0, md});
      chk(unit1_output_pin, pre[i]);
      first_timer_count <= 16'h1234;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(unit1_output_pin, post[i]);
      chk(unit1_irq, 1);
      @(posedge sys_clk);
      first_timer_count <= 16'h0000;
      apb(0, 8'h18, 0);
      chk(rd, 1);
      apb(1, 8'h18, 32'h1);
    end
    chk(n_t1, 1);
    $display("t_cmp done");
  endtask
  task automatic t_trig();
    apb(1, 8'h20, 32'h2);
    apb(1, 8'h10, 32'h01);
    apb(1, 8'h14, 32'hB);
    for (int e = 1; e >= 0; e--)
    begin
      adc_enable <= e[0];
      third_timer_count <= 16'h0100;
      repeat (4) @(posedge sys_clk);
      third_timer_count <= 16'h0000;
      @(posedge sys_clk);
    end
    chk(n_t3, 2);
    chk(n_adc, 1);
    chk(n_t1, 1);
    $display("t_trig done");
  endtask
  task automatic t_pwm();
    period_limit <= 8'h04;
    apb(1, 8'h00, 32'h02);
    // pin taken as an output here
    run <= 1;
    apb(1, 8'h08, 32'h1C);
    repeat (70) @(posedge sys_clk);
    chk(high_w, 9);
    apb(1, 8'h04, 32'h55);
    apb(0, 8'h04, 0);
    chk(rd, 2);
    apb(1, 8'h00, 32'hFF);
    repeat (70) @(posedge sys_clk);
    chk({31'h0, run_len > 16'd40}, 1);
    apb(1, 8'h00, 0);
    apb(1, 8'h08, 32'h0C);
    repeat (70) @(posedge sys_clk);
    chk(unit1_output_pin, 0);
    run <= 0;
    $display("t_pwm done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    t_regs();
    t_cmp();
    t_trig();
    t_pwm();
    close_out();
  end
endmodule // cpc_top_tb
